//--- shared/audio_playback_map.svh
// register offsets, field positions, reset values and timing counts of the audio playback unit
`ifndef AUDIO_PLAYBACK_MAP_SVH
`define AUDIO_PLAYBACK_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFF_AUDIO_CONTROL 8'h00
`define OFF_SAMPLE_FORMAT_CONTROL 8'h04
`define OFF_DAC_POWER_CONTROL 8'h08
`define OFF_THRESHOLD_IRQ 8'h0c
`define OFF_BUFFER_BASE_ADDRESS 8'h10
`define OFF_FIRST_BUFFER_END 8'h14
`define OFF_SECOND_BUFFER_END 8'h18
`define OFF_CURRENT_FETCH_ADDRESS 8'h1c
`define OFF_RESERVED_SLOT_A 8'h20
`define OFF_RESERVED_SLOT_B 8'h24
`define OFF_RESERVED_SLOT_C 8'h2c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_PLAYBACK_RUN 0
`define BIT_UNIT_SOFT_RESET 16
`define BIT_SAMPLE_SWAP 16
`define BIT_ZERO_CROSS_EN 25
`define BIT_DAC_POWER_DOWN 16
`define BIT_FIRST_IRQ_FLAG 0
`define BIT_SECOND_IRQ_FLAG 1
`define BIT_FIRST_IRQ_ENABLE 16
`define BIT_SECOND_IRQ_ENABLE 17

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define RST_AUDIO_CONTROL 32'h0000_0000
`define RST_SAMPLE_FORMAT_CONTROL 32'h0000_0001
`define RST_DAC_POWER_CONTROL 32'h0001_0000
`define RST_ZERO_WORD 32'h0000_0000
`define RST_RESERVED_SLOT_A 32'h7777_7777
`define RST_RESERVED_SLOT_B 32'h000D_0077
`define RST_RESERVED_SLOT_C 32'h0000_0000
`define WMASK_AUDIO_CONTROL 32'h0001_0001
`define WMASK_SAMPLE_FORMAT_CONTROL 32'h0201_0000
`define WMASK_DAC_POWER_CONTROL 32'h0001_0000

// ----------------------------------------------------------------
// timing and sizes
// ----------------------------------------------------------------
`define STROBE_COUNT_LAST 7'h7f
`define WORD_STEP 32'h0000_0004
`define HALF_LAST_WORD 2'h3
`define HALF_LAST_SAMPLE 3'h7

`endif

//--- shared/audio_playback_pkg.sv
// types shared by the audio playback unit
package audio_playback_pkg;

  // ----------------------------------------------------------------
  // fetch master states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FETCH_IDLE = 2'b00,
    FETCH_ADDR = 2'b01,
    FETCH_DATA = 2'b10
  } fetch_state_t;

  typedef logic [31:0] word_t;
  typedef logic [15:0] sample_t;

endpackage : audio_playback_pkg

//--- rtl/sample_fifo.sv
// two-half sample buffer: word writes from the fetcher, sample pops by the strobe
`timescale 1ns/100ps
`include "audio_playback_map.svh"
module sample_fifo
  import audio_playback_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic clear_i,
  // fill side
  input wire logic write_i,
  input wire word_t word_i,
  output logic fill_free_o,
  // drain side
  input wire logic pop_i,
  input wire logic swap_i,
  output logic sample_valid_o,
  output sample_t sample_o
);

  word_t store [0:7];
  logic [2:0] wr_ptr;
  logic [3:0] rd_ptr;
  logic [1:0] half_full;
  word_t rd_word;

  assign fill_free_o = !half_full[wr_ptr[2]];
  assign sample_valid_o = half_full[rd_ptr[3]];
  assign rd_word = store[rd_ptr[3:1]];
  // order bit picks which 16-bit half leaves first
  assign sample_o = (rd_ptr[0] ^ swap_i) ? rd_word[31:16] : rd_word[15:0];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (write_i && fill_free_o) begin
      store[wr_ptr] <= word_i;
    end
  end

  // ----------------------------------------------------------------
  // pointers and half flags
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (clear_i) begin
      wr_ptr <= 3'h0;
    end else if (write_i && fill_free_o) begin
      wr_ptr <= wr_ptr + 3'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (clear_i) begin
      rd_ptr <= 4'h0;
    end else if (pop_i && sample_valid_o) begin
      rd_ptr <= rd_ptr + 4'h1;
    end
  end

  generate
    for (genvar h = 0; h < 2; h++) begin : g_half
      always_ff @(posedge clock_i) begin
        if (clear_i) begin
          half_full[h] <= 1'b0;
        end else if (write_i && fill_free_o && wr_ptr[2] == h[0] && wr_ptr[1:0] == `HALF_LAST_WORD) begin
          half_full[h] <= 1'b1;
        end else if (pop_i && sample_valid_o && rd_ptr[3] == h[0] && rd_ptr[2:0] == `HALF_LAST_SAMPLE) begin
          half_full[h] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule : sample_fifo

//--- rtl/audio_playback_unit.sv
// audio playback unit: register slave, sample fetch master, strobe timer, dac feed
//
// How it works
// - unit fetches pcm samples from ram as a bus master, no cpu help
// - fetched words sit in a fifo of two 16-byte halves
// - samples go to a single-channel dac, 16 bits each
// - 7-bit counter on dac ticks; strobe each time it wraps from 127 to 0
// - two consecutive buffers: base to first end, then to second end
// - reaching a buffer end raises its threshold interrupt if enabled
// - control bit 16 at 1 resets internal logic and loads fetch address with base, other registers kept
// - control bit 0 runs playback when 1, stops it when 0
// - read-only register at 0x1c shows current fetch address
// - control and status registers sit behind a bus slave port
// - threshold flags set on buffer end, clear only on written 0
// - enable bits 16 and 17 gate the two threshold interrupts
// - order bit picks lower or upper half of a word as first sample
`timescale 1ns/100ps
`include "audio_playback_map.svh"
module audio_playback_unit
  import audio_playback_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // register slave port
  input wire logic s_hsel_i,
  input wire logic [31:0] s_haddr_i,
  input wire logic [1:0] s_htrans_i,
  input wire logic s_hwrite_i,
  input wire logic [2:0] s_hsize_i,
  input wire logic [31:0] s_hwdata_i,
  input wire logic s_hready_i,
  output logic [31:0] s_hrdata_o,
  output logic s_hreadyout_o,
  output logic [1:0] s_hresp_o,
  // sample fetch master port
  output logic [31:0] m_haddr_o,
  output logic [1:0] m_htrans_o,
  output logic m_hwrite_o,
  output logic [2:0] m_hsize_o,
  output logic [2:0] m_hburst_o,
  input wire logic [31:0] m_hrdata_i,
  input wire logic m_hready_i,
  input wire logic [1:0] m_hresp_i,
  // dac side
  input wire logic dac_tick_i,
  output logic [15:0] dac_sample_o,
  output logic conversion_strobe_o,
  output logic dac_power_down_o,
  output logic threshold_irq_o
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  word_t audio_control;
  word_t sample_format_control;
  word_t dac_power_control;
  word_t buffer_base_address;
  word_t first_buffer_end_address;
  word_t second_buffer_end_address;
  word_t current_fetch_address;
  word_t reserved_slot_a;
  word_t reserved_slot_b;
  word_t reserved_slot_c;
  logic first_threshold_irq_enable;
  logic second_threshold_irq_enable;
  logic first_threshold_irq_flag;
  logic second_threshold_irq_flag;

  logic playback_run;
  logic unit_soft_reset;
  logic logic_clear;
  logic wr_pend;
  logic [7:0] wr_off;
  logic rd_take;
  logic wr_take;
  logic wr_now;
  word_t next_rdata;

  fetch_state_t fetch_state;
  logic word_done;
  logic hit_first_end;
  logic hit_second_end;
  logic fill_free;
  logic [6:0] strobe_count;
  logic strobe_due;
  logic sample_valid;
  sample_t sample_head;

  assign playback_run = audio_control[`BIT_PLAYBACK_RUN];
  assign unit_soft_reset = audio_control[`BIT_UNIT_SOFT_RESET];
  assign logic_clear = !resetn_i || unit_soft_reset;
  assign rd_take = s_hsel_i && s_htrans_i[1] && s_hready_i && !s_hwrite_i;
  assign wr_take = s_hsel_i && s_htrans_i[1] && s_hready_i && s_hwrite_i;
  assign wr_now = wr_pend;

  // ----------------------------------------------------------------
  // slave handshake: writes take one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      wr_pend <= 1'b0;
      wr_off <= 8'h00;
      s_hreadyout_o <= 1'b1;
      s_hresp_o <= 2'b00;
    end else if (wr_pend) begin
      wr_pend <= 1'b0;
      s_hreadyout_o <= 1'b1;
    end else if (wr_take) begin
      wr_pend <= 1'b1;
      wr_off <= s_haddr_i[7:0];
      s_hreadyout_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      audio_control <= `RST_AUDIO_CONTROL;
      sample_format_control <= `RST_SAMPLE_FORMAT_CONTROL;
      dac_power_control <= `RST_DAC_POWER_CONTROL;
      buffer_base_address <= `RST_ZERO_WORD;
      first_buffer_end_address <= `RST_ZERO_WORD;
      second_buffer_end_address <= `RST_ZERO_WORD;
      reserved_slot_a <= `RST_RESERVED_SLOT_A;
      reserved_slot_b <= `RST_RESERVED_SLOT_B;
      reserved_slot_c <= `RST_RESERVED_SLOT_C;
      first_threshold_irq_enable <= 1'b0;
      second_threshold_irq_enable <= 1'b0;
    end else if (wr_now) begin
      case (wr_off)
        `OFF_AUDIO_CONTROL: begin
          audio_control <= s_hwdata_i & `WMASK_AUDIO_CONTROL;
        end
        `OFF_SAMPLE_FORMAT_CONTROL: begin
          sample_format_control <= (s_hwdata_i & `WMASK_SAMPLE_FORMAT_CONTROL) | `RST_SAMPLE_FORMAT_CONTROL;
        end
        `OFF_DAC_POWER_CONTROL: begin
          dac_power_control <= s_hwdata_i & `WMASK_DAC_POWER_CONTROL;
        end
        `OFF_THRESHOLD_IRQ: begin
          first_threshold_irq_enable <= s_hwdata_i[`BIT_FIRST_IRQ_ENABLE];
          second_threshold_irq_enable <= s_hwdata_i[`BIT_SECOND_IRQ_ENABLE];
        end
        `OFF_BUFFER_BASE_ADDRESS: begin
          buffer_base_address <= s_hwdata_i;
        end
        `OFF_FIRST_BUFFER_END: begin
          first_buffer_end_address <= s_hwdata_i;
        end
        `OFF_SECOND_BUFFER_END: begin
          second_buffer_end_address <= s_hwdata_i;
        end
        `OFF_RESERVED_SLOT_A: begin
          reserved_slot_a <= s_hwdata_i;
        end
        `OFF_RESERVED_SLOT_B: begin
          reserved_slot_b <= s_hwdata_i;
        end
        `OFF_RESERVED_SLOT_C: begin
          reserved_slot_c <= s_hwdata_i;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // threshold flags: set wins over a written 0
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      first_threshold_irq_flag <= 1'b0;
      second_threshold_irq_flag <= 1'b0;
    end else begin
      if (word_done && hit_first_end) begin
        first_threshold_irq_flag <= 1'b1;
      end else if (wr_now && wr_off == `OFF_THRESHOLD_IRQ && !s_hwdata_i[`BIT_FIRST_IRQ_FLAG]) begin
        first_threshold_irq_flag <= 1'b0;
      end
      if (word_done && hit_second_end) begin
        second_threshold_irq_flag <= 1'b1;
      end else if (wr_now && wr_off == `OFF_THRESHOLD_IRQ && !s_hwdata_i[`BIT_SECOND_IRQ_FLAG]) begin
        second_threshold_irq_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      threshold_irq_o <= 1'b0;
      dac_power_down_o <= 1'b1;
    end else begin
      threshold_irq_o <= (first_threshold_irq_flag && first_threshold_irq_enable)
                      || (second_threshold_irq_flag && second_threshold_irq_enable);
      dac_power_down_o <= dac_power_control[`BIT_DAC_POWER_DOWN];
    end
  end

  // ----------------------------------------------------------------
  // register reads: data captured in the address phase
  // ----------------------------------------------------------------
  always_comb begin
    case (s_haddr_i[7:0])
      `OFF_AUDIO_CONTROL: next_rdata = audio_control;
      `OFF_SAMPLE_FORMAT_CONTROL: next_rdata = sample_format_control;
      `OFF_DAC_POWER_CONTROL: next_rdata = dac_power_control;
      `OFF_THRESHOLD_IRQ: begin
        next_rdata = `RST_ZERO_WORD;
        next_rdata[`BIT_FIRST_IRQ_ENABLE] = first_threshold_irq_enable;
        next_rdata[`BIT_SECOND_IRQ_ENABLE] = second_threshold_irq_enable;
        next_rdata[`BIT_FIRST_IRQ_FLAG] = first_threshold_irq_flag;
        next_rdata[`BIT_SECOND_IRQ_FLAG] = second_threshold_irq_flag;
      end
      `OFF_BUFFER_BASE_ADDRESS: next_rdata = buffer_base_address;
      `OFF_FIRST_BUFFER_END: next_rdata = first_buffer_end_address;
      `OFF_SECOND_BUFFER_END: next_rdata = second_buffer_end_address;
      `OFF_CURRENT_FETCH_ADDRESS: next_rdata = current_fetch_address;
      `OFF_RESERVED_SLOT_A: next_rdata = reserved_slot_a;
      `OFF_RESERVED_SLOT_B: next_rdata = reserved_slot_b;
      `OFF_RESERVED_SLOT_C: next_rdata = reserved_slot_c;
      default: next_rdata = `RST_ZERO_WORD;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      s_hrdata_o <= `RST_ZERO_WORD;
    end else if (rd_take) begin
      s_hrdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // fetch master: single word reads, one at a time
  // ----------------------------------------------------------------
  assign word_done = (fetch_state == FETCH_DATA) && m_hready_i;
  assign hit_first_end = current_fetch_address == first_buffer_end_address;
  assign hit_second_end = current_fetch_address == second_buffer_end_address;

  always_ff @(posedge clock_i) begin
    if (logic_clear) begin
      fetch_state <= FETCH_IDLE;
      m_htrans_o <= 2'b00;
      m_haddr_o <= `RST_ZERO_WORD;
    end else begin
      case (fetch_state)
        FETCH_IDLE: begin
          if (playback_run && fill_free) begin
            fetch_state <= FETCH_ADDR;
            m_htrans_o <= 2'b10;
            m_haddr_o <= current_fetch_address;
          end
        end
        FETCH_ADDR: begin
          if (m_hready_i) begin
            fetch_state <= FETCH_DATA;
            m_htrans_o <= 2'b00;
          end
        end
        FETCH_DATA: begin
          if (m_hready_i) begin
            fetch_state <= FETCH_IDLE;
          end
        end
        default: begin
          fetch_state <= FETCH_IDLE;
          m_htrans_o <= 2'b00;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      m_hwrite_o <= 1'b0;
      m_hsize_o <= 3'b000;
      m_hburst_o <= 3'b000;
    end else begin
      m_hwrite_o <= 1'b0;
      m_hsize_o <= 3'b010;
      m_hburst_o <= 3'b000;
    end
  end

  // ----------------------------------------------------------------
  // ping-pong address walk
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      current_fetch_address <= `RST_ZERO_WORD;
    end else if (unit_soft_reset) begin
      current_fetch_address <= buffer_base_address;
    end else if (word_done) begin
      if (hit_second_end) begin
        current_fetch_address <= buffer_base_address;
      end else begin
        current_fetch_address <= current_fetch_address + `WORD_STEP;
      end
    end
  end

  // ----------------------------------------------------------------
  // sample buffer
  // ----------------------------------------------------------------
  sample_fifo u_sample_fifo (
    .clock_i(clock_i),
    .clear_i(logic_clear),
    .write_i(word_done && m_hresp_i == 2'b00),
    .word_i(m_hrdata_i),
    .fill_free_o(fill_free),
    .pop_i(strobe_due),
    .swap_i(sample_format_control[`BIT_SAMPLE_SWAP]),
    .sample_valid_o(sample_valid),
    .sample_o(sample_head)
  );

  // ----------------------------------------------------------------
  // strobe timer and dac feed
  // ----------------------------------------------------------------
  assign strobe_due = playback_run && dac_tick_i && strobe_count == `STROBE_COUNT_LAST;

  always_ff @(posedge clock_i) begin
    if (logic_clear) begin
      strobe_count <= 7'h00;
    end else if (playback_run && dac_tick_i) begin
      strobe_count <= strobe_count + 7'h01;
    end
  end

  always_ff @(posedge clock_i) begin
    if (logic_clear) begin
      conversion_strobe_o <= 1'b0;
      dac_sample_o <= 16'h0000;
    end else begin
      conversion_strobe_o <= strobe_due;
      if (strobe_due && sample_valid) begin
        dac_sample_o <= sample_head;
      end
    end
  end

endmodule : audio_playback_unit

//--- tb/ram_model.sv
// behavioural system ram answering the fetch master
`timescale 1ns/100ps
module ram_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // bus from the fetch master
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic [1:0] wait_i,
  output logic hready_o,
  output logic [31:0] hrdata_o,
  output logic [1:0] hresp_o
);
  logic pend;
  logic [1:0] cnt;
  logic [31:0] addr;
  logic [31:0] word;
  // word content follows its address
  assign word = {~addr[15:0], addr[15:0]};
  assign hready_o = !(pend && cnt != 2'b00);
  // data valid only at the closing beat, inverted otherwise
  assign hrdata_o = (pend && hready_o) ? word : ~word;
  assign hresp_o = 2'b00;
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pend <= 1'b0;
      cnt <= 2'b00;
      addr <= 32'h0000_0000;
    end else if (htrans_i[1] && hready_o) begin
      pend <= 1'b1;
      cnt <= wait_i;
      addr <= haddr_i;
    end else if (cnt != 2'b00) begin
      cnt <= cnt - 2'b01;
    end else begin
      pend <= 1'b0;
    end
  end
endmodule : ram_model

//--- tb/audio_playback_unit_monitor.sv
// port checker of the audio playback unit
`timescale 1ns/100ps
module audio_playback_unit_monitor (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // register slave port
  input wire logic s_hsel_i,
  input wire logic [1:0] s_htrans_i,
  input wire logic s_hwrite_i,
  input wire logic s_hready_i,
  input wire logic [31:0] s_hrdata_o,
  input wire logic s_hreadyout_o,
  input wire logic [1:0] s_hresp_o,
  // fetch master port
  input wire logic [31:0] m_haddr_o,
  input wire logic [1:0] m_htrans_o,
  input wire logic m_hwrite_o,
  input wire logic [2:0] m_hsize_o,
  input wire logic [2:0] m_hburst_o,
  input wire logic m_hready_i,
  // dac side
  input wire logic dac_tick_i,
  input wire logic [15:0] dac_sample_o,
  input wire logic conversion_strobe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  logic take;
  logic rd_seen;
  logic [15:0] gap;
  assign take = s_hsel_i && s_htrans_i[1] && s_hready_i;
  assign rd_seen = take && !s_hwrite_i;
  // ticks seen since the last strobe
  always_ff @(posedge clock_i) begin
    if (!resetn_i || conversion_strobe_o) begin
      gap <= 16'h0000;
    end else if (dac_tick_i && gap != 16'hffff) begin
      gap <= gap + 16'h0001;
    end
  end
  property p_strobe_pulse; conversion_strobe_o |=> !conversion_strobe_o; endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe longer than one cycle");
  property p_strobe_spacing; conversion_strobe_o |-> gap >= 16'h007f; endproperty
  a_strobe_spacing: assert property (p_strobe_spacing) else $error("strobe before 128 ticks");
  property p_sample_moves; $changed(dac_sample_o) |-> conversion_strobe_o || dac_sample_o == 16'h0000; endproperty
  a_sample_moves: assert property (p_sample_moves) else $error("sample changed without strobe");
  property p_hresp_okay; s_hresp_o == 2'b00; endproperty
  a_hresp_okay: assert property (p_hresp_okay) else $error("slave response not okay");
  property p_read_nowait; take && !s_hwrite_i |=> s_hreadyout_o; endproperty
  a_read_nowait: assert property (p_read_nowait) else $error("read inserted a wait");
  property p_write_wait; take && s_hwrite_i |=> !s_hreadyout_o ##1 s_hreadyout_o; endproperty
  a_write_wait: assert property (p_write_wait) else $error("write wait not one cycle");
  property p_rdata_stands; $changed(s_hrdata_o) |-> $past(rd_seen); endproperty
  a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved without read");
  property p_master_single;
    m_htrans_o == 2'b10 |-> !m_hwrite_o && m_hsize_o == 3'b010 && m_hburst_o == 3'b000 && m_haddr_o[1:0] == 2'b00;
  endproperty
  a_master_single: assert property (p_master_single) else $error("fetch not a single word read");
  property p_no_pipeline; m_htrans_o == 2'b10 && m_hready_i |=> m_htrans_o == 2'b00; endproperty
  a_no_pipeline: assert property (p_no_pipeline) else $error("fetch pipelined");
endmodule : audio_playback_unit_monitor

//--- tb/tb_audio_playback_unit.sv
// self-checking bench of the audio playback unit
`timescale 1ns/100ps
module tb_audio_playback_unit
  import audio_playback_pkg::*;
;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic s_hsel_i = 1'b0;
  logic s_hwrite_i = 1'b0;
  logic dac_tick_i = 1'b0;
  logic tick_slow = 1'b0;
  logic [1:0] s_htrans_i = 2'b00;
  logic [1:0] wait_n = 2'b00;
  word_t s_haddr_i = 32'h0000_0000;
  word_t s_hwdata_i = 32'h0000_0000;
  word_t s_hrdata_o, m_haddr_o, m_hrdata_i, rd;
  logic [1:0] s_hresp_o, m_htrans_o, m_hresp_i;
  logic s_hready_i, s_hreadyout_o, m_hwrite_o, m_hready_i;
  logic [2:0] m_hsize_o, m_hburst_o;
  sample_t dac_sample_o;
  logic conversion_strobe_o, dac_power_down_o, threshold_irq_o;
  int n_errors = 0;
  int cmp_count = 0;
  assign s_hready_i = s_hreadyout_o;
  always #5 clock_i = ~clock_i;
  // dac tick: every cycle, or every other cycle in slow mode
  always @(posedge clock_i) begin
    #1;
    dac_tick_i = !tick_slow || !dac_tick_i;
  end
  audio_playback_unit dut (.clock_i, .resetn_i, .s_hsel_i, .s_haddr_i, .s_htrans_i, .s_hwrite_i,
    .s_hsize_i(3'b010), .s_hwdata_i, .s_hready_i, .s_hrdata_o, .s_hreadyout_o, .s_hresp_o, .m_haddr_o,
    .m_htrans_o, .m_hwrite_o, .m_hsize_o, .m_hburst_o, .m_hrdata_i, .m_hready_i, .m_hresp_i, .dac_tick_i,
    .dac_sample_o, .conversion_strobe_o, .dac_power_down_o, .threshold_irq_o);
  ram_model ram (.clock_i, .resetn_i, .haddr_i(m_haddr_o), .htrans_i(m_htrans_o), .wait_i(wait_n),
    .hready_o(m_hready_i), .hrdata_o(m_hrdata_i), .hresp_o(m_hresp_i));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  task automatic cmp32(input word_t got, input word_t exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp32
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : cyc
  task automatic bus(input logic wr, input logic [7:0] a, input word_t d);
    int i;
    s_hsel_i = 1'b1;
    s_htrans_i = 2'b10;
    s_hwrite_i = wr;
    s_haddr_i = {24'h00_0000, a};
    cyc(1);
    s_hsel_i = 1'b0;
    s_htrans_i = 2'b00;
    s_haddr_i = ~s_haddr_i;
    s_hwdata_i = d;
    for (i = 0; i < 20 && s_hreadyout_o !== 1'b1; i++) begin
      cyc(1);
    end
    if (i == 20) begin
      n_errors++;
      close_out();
    end
    rd = s_hrdata_o;
    cyc(1);
    s_hwdata_i = ~d;
  endtask : bus
  task automatic wr(input logic [7:0] a, input word_t d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input word_t e);
    bus(1'b0, a, 32'h0000_0000);
    cmp32(rd, e);
  endtask : rdc
  task automatic next_sample(input sample_t e);
    int i;
    for (i = 0; i < 400 && conversion_strobe_o !== 1'b1; i++) begin
      cyc(1);
    end
    if (i == 400) begin
      n_errors++;
      close_out();
    end
    cmp32({16'h0000, dac_sample_o}, {16'h0000, e});
    cyc(1);
  endtask : next_sample
  // k-th sample: two per word, eight words then back to base
  function automatic sample_t exp_s(input word_t b, input int k, input logic sw);
    word_t a;
    a = b + 32'(4 * ((k / 2) % 8));
    return (((k % 2) == 1) ^ sw) ? ~a[15:0] : a[15:0];
  endfunction : exp_s
  task automatic start(input word_t b, input logic sw, input logic [1:0] w);
    wait_n = w;
    wr(8'h04, {15'h0000, sw, 16'h0000});
    wr(8'h10, b);
    wr(8'h14, b + 32'h0000_000c);
    wr(8'h18, b + 32'h0000_001c);
    wr(8'h00, 32'h0001_0000);
    rdc(8'h1c, b);
    wr(8'h00, 32'h0000_0000);
    rdc(8'h10, b);
    wr(8'h00, 32'h0000_0001);
  endtask : start
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] offs [12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h2c, 8'h28};
    word_t vals [12] = '{32'h0000_0000, 32'h0000_0001, 32'h0001_0000, 32'h0000_0000, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h7777_7777, 32'h000D_0077, 32'h0000_0000, 32'h0000_0000};
    for (int i = 0; i < 12; i++) begin
      rdc(offs[i], vals[i]);
    end
    wr(8'h1c, 32'hffff_ffff);
    rdc(8'h1c, 32'h0000_0000);
    wr(8'h28, 32'h1234_5678);
    rdc(8'h28, 32'h0000_0000);
    wr(8'h14, 32'h1234_5678);
    rdc(8'h14, 32'h1234_5678);
    wr(8'h04, 32'hffff_ffff);
    rdc(8'h04, 32'h0201_0001);
    wr(8'h24, 32'h0123_4567);
    rdc(8'h24, 32'h0123_4567);
    cmp32({31'h0, dac_power_down_o}, 32'h0000_0001);
    wr(8'h08, 32'h0000_0000);
    cmp32({31'h0, dac_power_down_o}, 32'h0000_0000);
    rdc(8'h08, 32'h0000_0000);
    wr(8'h0c, 32'h0003_0003);
    rdc(8'h0c, 32'h0003_0000);
  endtask : t_regs
  task automatic t_play;
    int n;
    start(32'h0000_0100, 1'b0, 2'b00);
    for (int k = 0; k < 18; k++) begin
      next_sample(exp_s(32'h0000_0100, k, 1'b0));
    end
    cmp32({31'h0, threshold_irq_o}, 32'h0000_0001);
    wr(8'h00, 32'h0000_0000);
    cyc(20);
    rdc(8'h1c, 32'h0000_0100);
    rdc(8'h0c, 32'h0003_0003);
    wr(8'h0c, 32'h0000_0003);
    cyc(3);
    cmp32({31'h0, threshold_irq_o}, 32'h0000_0000);
    rdc(8'h0c, 32'h0000_0003);
    wr(8'h0c, 32'h0000_0000);
    rdc(8'h0c, 32'h0000_0000);
    n = 0;
    repeat (300) begin
      cyc(1);
      n += int'(conversion_strobe_o === 1'b1);
    end
    cmp32(32'(n), 32'h0000_0000);
  endtask : t_play
  task automatic t_swap;
    tick_slow = 1'b1;
    start(32'h0000_2000, 1'b1, 2'b10);
    for (int k = 0; k < 4; k++) begin
      next_sample(exp_s(32'h0000_2000, k, 1'b1));
    end
    wr(8'h00, 32'h0000_0000);
  endtask : t_swap
  initial begin
    cyc(10);
    resetn_i = 1'b1;
    t_regs();
    t_play();
    t_swap();
    close_out();
  end
endmodule : tb_audio_playback_unit
bind audio_playback_unit audio_playback_unit_monitor mon (.clock_i, .resetn_i, .s_hsel_i, .s_htrans_i,
  .s_hwrite_i, .s_hready_i, .s_hrdata_o, .s_hreadyout_o, .s_hresp_o, .m_haddr_o, .m_htrans_o, .m_hwrite_o,
  .m_hsize_o, .m_hburst_o, .m_hready_i, .dac_tick_i, .dac_sample_o, .conversion_strobe_o);
